// *** hdl/css_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the clock source switcher.
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
// ==========================================================================
// Register byte addresses.
`define CSS_OSC_CONTROL_ADDR  12'h000
`define CSS_UNLOCK_ADDR       12'h004
`define CSS_PERIPH_DIS1_ADDR  12'h008
`define CSS_PERIPH_DIS5_ADDR  12'h00C
`define CSS_STATUS_ADDR       12'h010
// ==========================================================================
// Oscillator control register fields.
`define CSS_REQ_BIT           0
`define CSS_FAIL_BIT          3
`define CSS_LOCK_BIT          5
`define CSS_NEXT_LSB          8
`define CSS_CUR_LSB           12
// ==========================================================================
// Unlock keys: high byte key and low byte key written to the unlock register.
`define CSS_KEY_HIGH          32'h0000_A55A
`define CSS_KEY_LOW           32'h0000_5AA5
// ==========================================================================
// Writable masks and reset values of the module-disable registers.
`define CSS_DIS1_MASK         16'h38F9
`define CSS_DIS5_MASK         16'h000F
`define CSS_DIS_RESET         16'h0000
// ==========================================================================
// Cycles of the new clock counted before the swap.
`define CSS_SETTLE_CYCLES     4'hA
`endif

// *** hdl/css_pkg.sv ***
// Types shared by the clock source switcher.
package css_pkg;
  // Clock source codes.
  typedef enum logic [2:0] {
    CSS_SRC_FAST_RC   = 3'h0,
    CSS_SRC_FRC_PLL   = 3'h1,
    CSS_SRC_PRIMARY   = 3'h2,
    CSS_SRC_PRI_PLL   = 3'h3,
    CSS_SRC_SECONDARY = 3'h4,
    CSS_SRC_LOW_POWER = 3'h5
  } css_src_e;
  // Switch sequence states, Gray coded from idle up to swap.
  typedef enum logic [2:0] {
    CSS_IDLE    = 3'h0,
    CSS_COMPARE = 3'h1,
    CSS_START   = 3'h3,
    CSS_SETTLE  = 3'h2,
    CSS_SWAP    = 3'h6
  } css_state_e;
endpackage

// *** hdl/css_clock_switch.sv ***
// Clock source switcher with APB register access and module-disable registers.
`timescale 1ns/1ps
`include "css_defines.svh"
// What this block does
// - Software may select any of six sources.
// - Primary submode comes only from configuration.
// - Switching enabled only when config bit low.
// - Disabled: ignore next field, current shows initial.
// - Disabled: request bit held zero.
// - Equal sources abort and clear request.
// - Valid switch clears lock and fail flags.
// - Start new oscillator; crystal waits startup timer.
// - PLL source waits for lock.
// - Count ten new-clock cycles, then swap.
// - Completion clears request, copies next to current.
// - Turn off old source, with keep-on exceptions.
// - Processor keeps running during switching.
// - Disable bits 7..3,0 gate serial and converter.
// - Disable5 bits 3..0 gate capture/compare 4..1.
// - Unimplemented disable bits read zero.
module css_clock_switch
  import css_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        switch_monitor_cfg_n,
  input  wire logic [2:0]  initial_source_cfg,
  input  wire logic [1:0]  primary_submode_cfg,
  input  wire logic        watchdog_on,
  input  wire logic        secondary_osc_keep_on,
  input  wire logic [3:0]  osc_running,
  input  wire logic        osc_startup_timer_done,
  input  wire logic        pll_locked,
  input  wire logic        clock_fail_event,
  input  wire logic        new_clock_tick,
  output logic      [3:0]  osc_enable,
  output logic             pll_enable,
  output logic      [2:0]  system_clock_sel,
  output logic      [1:0]  primary_submode,
  output logic      [15:0] peripheral_disable_1,
  output logic      [15:0] peripheral_disable_5
);

  // ========================================================================
  // Helpers.
  // Maps a source code onto its one-hot oscillator enable bit: 0 primary, 1 secondary,
  // 2 fast RC, 3 low-power RC.
  function automatic logic [3:0] css_osc_of(input logic [2:0] src);
    case (src)
      CSS_SRC_PRIMARY, CSS_SRC_PRI_PLL: css_osc_of = 4'h1;
      CSS_SRC_SECONDARY:                css_osc_of = 4'h2;
      CSS_SRC_LOW_POWER:                css_osc_of = 4'h8;
      default:                          css_osc_of = 4'h4;
    endcase
  endfunction
  // True when the source runs through the PLL.
  function automatic logic css_uses_pll(input logic [2:0] src);
    css_uses_pll = (src == CSS_SRC_FRC_PLL) || (src == CSS_SRC_PRI_PLL);
  endfunction

  // ========================================================================
  // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree.
  logic [4:0] sync1_reg;              // First stage, read only by stage two.
  logic [4:0] sync2_reg;              // Second stage.
  logic [4:0] sync3_reg;              // Third stage.
  logic [4:0] clean_reg;              // Filtered levels.
  logic [4:0] clean_next;             // Next filtered levels.
  logic       ost_done;               // Startup timer expired.
  logic       lock_seen;              // PLL lock detected.
  logic       fail_seen;              // Clock failure seen.
  logic       tick_seen;              // Level of the new clock divided tick.
  logic       tick_prev_reg;          // Previous tick level for edge detection.
  logic       tick_edge;              // One new-clock cycle elapsed.

  // The filter only moves when the later two stages agree.
  always_comb begin
    clean_next = clean_reg;
    for (int i = 0; i < 5; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        clean_next[i] = sync3_reg[i];
      end
    end
  end

  // Registers of the synchroniser chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg     <= 5'h00;
      sync2_reg     <= 5'h00;
      sync3_reg     <= 5'h00;
      clean_reg     <= 5'h00;
      tick_prev_reg <= 1'b0;
    end else begin
      sync1_reg     <= {new_clock_tick, clock_fail_event, pll_locked,
                        osc_startup_timer_done, 1'b0};
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      clean_reg     <= clean_next;
      tick_prev_reg <= tick_seen;
    end
  end

  assign ost_done  = clean_reg[1];
  assign lock_seen = clean_reg[2];
  assign fail_seen = clean_reg[3];
  assign tick_seen = clean_reg[4];
  // Each toggle of the tick pin stands for one cycle of the new clock.
  assign tick_edge = tick_seen ^ tick_prev_reg;

  // ========================================================================
  // Configuration capture after reset release.
  logic       cfg_loaded_reg;         // Configuration has been sampled.
  logic       sw_enable_reg;          // Clock switching allowed.
  logic [1:0] submode_reg;            // Primary oscillator submode.
  logic [2:0] init_src_reg;           // Initial source after reset.

  // Straps are caught by the clock once reset has been released; software
  // has no path to the submode, so a switch never changes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_reg <= 1'b0;
      sw_enable_reg  <= 1'b0;
      submode_reg    <= 2'h0;
      init_src_reg   <= 3'h0;
    end else if (!cfg_loaded_reg) begin
      cfg_loaded_reg <= 1'b1;
      sw_enable_reg  <= ~switch_monitor_cfg_n;
      submode_reg    <= primary_submode_cfg;
      init_src_reg   <= initial_source_cfg;
    end
  end

  // ========================================================================
  // APB decode and switch sequence.
  logic        wr_en;                 // Write access phase completes.
  logic [1:0]  unlock_reg, unlock_next;  // Bit 1 high byte, bit 0 low byte.
  logic [2:0]  next_reg, next_next;   // Next-source field.
  logic [2:0]  cur_reg, cur_next;     // Current-source field.
  logic        req_reg, req_next;     // Switch request bit.
  logic        lock_reg, lock_next;   // PLL lock status bit.
  logic        fail_reg, fail_next;   // Clock fail flag.
  logic [3:0]  cnt_reg, cnt_next;     // New-clock cycle counter.
  logic [3:0]  oen_reg, oen_next;     // Oscillator enables.
  logic [15:0] dis1_reg, dis1_next;   // Module-disable register 1.
  logic [15:0] dis5_reg, dis5_next;   // Module-disable register 5.
  logic        sw_on;                 // Switching active.
  css_state_e  state_reg, state_next; // Sequencer state.

  assign wr_en = psel && penable && pwrite;
  assign sw_on = sw_enable_reg && cfg_loaded_reg;

  // Next-state logic of registers and the switch sequencer.
  always_comb begin
    unlock_next = unlock_reg;
    next_next   = next_reg;
    cur_next    = cur_reg;
    req_next    = req_reg;
    lock_next   = lock_reg;
    fail_next   = fail_reg | fail_seen;
    cnt_next    = cnt_reg;
    oen_next    = oen_reg;
    dis1_next   = dis1_reg;
    dis5_next   = dis5_reg;
    state_next  = state_reg;
    // Before the straps are read the current source tracks them.
    if (!cfg_loaded_reg || !sw_on) begin
      cur_next = cfg_loaded_reg ? init_src_reg : initial_source_cfg;
      oen_next = css_osc_of(cur_next) | oen_reg;
    end
    // Any completed write other than a key spends the unlock.
    if (wr_en) begin
      unlock_next = 2'h0;
      case (paddr)
        `CSS_UNLOCK_ADDR: begin
          if (pwdata == `CSS_KEY_HIGH) unlock_next = 2'h2;
          else if (pwdata == `CSS_KEY_LOW) unlock_next = 2'h1;
        end
        `CSS_OSC_CONTROL_ADDR: begin
          // any source code may be written while the high byte is open.
          if (unlock_reg[1] && pstrb[1]) begin
            next_next = pwdata[`CSS_NEXT_LSB +: 3];
          end
          // the request is only accepted while switching is enabled.
          if (unlock_reg[0] && pstrb[0] && sw_on && pwdata[`CSS_REQ_BIT]) begin
            req_next = 1'b1;
          end
        end
        `CSS_PERIPH_DIS1_ADDR: begin
          if (pstrb[0]) dis1_next[7:0] = pwdata[7:0] & 8'(`CSS_DIS1_MASK);
          if (pstrb[1]) dis1_next[15:8] = pwdata[15:8] & 8'(`CSS_DIS1_MASK >> 8);
        end
        `CSS_PERIPH_DIS5_ADDR: begin
          if (pstrb[0]) dis5_next[7:0] = pwdata[7:0] & 8'(`CSS_DIS5_MASK);
        end
        default: begin
        end
      endcase
    end
    // Sequencer; the processor side is never stalled by it.
    case (state_reg)
      CSS_IDLE: begin
        if (req_reg && sw_on) state_next = CSS_COMPARE;
      end
      CSS_COMPARE: begin
        if (next_reg == cur_reg) begin
          req_next   = 1'b0;
          state_next = CSS_IDLE;
        end else begin
          lock_next  = 1'b0;
          fail_next  = 1'b0;
          oen_next   = oen_reg | css_osc_of(next_reg);
          state_next = CSS_START;
        end
      end
      CSS_START: begin
        // crystal submode waits for the startup timer.
        if (((css_osc_of(next_reg) & osc_running) != 4'h0)
            && ((css_osc_of(next_reg) & 4'h1) == 4'h0 || submode_reg != 2'h0 || ost_done)
            && (!css_uses_pll(next_reg) || lock_seen)) begin
          lock_next  = css_uses_pll(next_reg);
          cnt_next   = 4'h0;
          state_next = CSS_SETTLE;
        end
      end
      CSS_SETTLE: begin
        if (tick_edge) cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == `CSS_SETTLE_CYCLES) state_next = CSS_SWAP;
      end
      CSS_SWAP: begin
        cur_next   = next_reg;
        req_next   = 1'b0;
        // old source off unless it is kept on.
        oen_next   = css_osc_of(next_reg)
                   | (watchdog_on || sw_on ? 4'h8 : 4'h0)
                   | (secondary_osc_keep_on ? 4'h2 : 4'h0);
        state_next = CSS_IDLE;
      end
      default: state_next = CSS_IDLE;
    endcase
    if (!sw_on) req_next = 1'b0;
  end

  // Register stage of the control state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= 2'h0;
      next_reg   <= 3'h0;
      cur_reg    <= 3'h0;
      req_reg    <= 1'b0;
      lock_reg   <= 1'b0;
      fail_reg   <= 1'b0;
      cnt_reg    <= 4'h0;
      oen_reg    <= 4'h0;
      dis1_reg   <= `CSS_DIS_RESET;
      dis5_reg   <= `CSS_DIS_RESET;
      state_reg  <= CSS_IDLE;
    end else begin
      unlock_reg <= unlock_next;
      next_reg   <= next_next;
      cur_reg    <= cur_next;
      req_reg    <= req_next;
      lock_reg   <= lock_next;
      fail_reg   <= fail_next;
      cnt_reg    <= cnt_next;
      oen_reg    <= oen_next;
      dis1_reg   <= dis1_next;
      dis5_reg   <= dis5_next;
      state_reg  <= state_next;
    end
  end

  // ========================================================================
  // Read path: registered read data, zero-wait answers.
  logic [31:0] rd_next;               // Read data for the current address.
  logic        err_next;              // Unmapped address.

  // Unimplemented bits read as zero by masking.
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr)
      `CSS_OSC_CONTROL_ADDR: begin
        rd_next[`CSS_CUR_LSB +: 3]  = cur_reg;
        rd_next[`CSS_NEXT_LSB +: 3] = next_reg;
        rd_next[`CSS_LOCK_BIT]      = lock_reg;
        rd_next[`CSS_FAIL_BIT]      = fail_reg;
        rd_next[`CSS_REQ_BIT]       = req_reg;
      end
      `CSS_UNLOCK_ADDR:      rd_next = {30'h0, unlock_reg};
      `CSS_PERIPH_DIS1_ADDR: rd_next = {16'h0000, dis1_reg & `CSS_DIS1_MASK};
      `CSS_PERIPH_DIS5_ADDR: rd_next = {16'h0000, dis5_reg & `CSS_DIS5_MASK};
      `CSS_STATUS_ADDR:      rd_next = {27'h0, sw_on, oen_reg};
      default:               err_next = 1'b1;
    endcase
  end

  // Read data is captured in the setup cycle so it stands in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata  <= rd_next;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_next;

  // ========================================================================
  // Outputs.
  assign osc_enable           = oen_reg;
  assign pll_enable           = css_uses_pll(next_reg) && (state_reg != CSS_IDLE)
                                || css_uses_pll(cur_reg);
  assign system_clock_sel     = cur_reg;
  assign primary_submode      = submode_reg;
  assign peripheral_disable_1 = dis1_reg;
  assign peripheral_disable_5 = dis5_reg;

endmodule

// *** test/css_clock_switch_chk.sv ***
// Concurrent checks on the ports of the clock source switcher.
`timescale 1ns/1ps
`include "css_defines.svh"
module css_clock_switch_chk
  import css_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        switch_monitor_cfg_n,
  input wire logic [2:0]  initial_source_cfg,
  input wire logic [1:0]  primary_submode_cfg,
  input wire logic        watchdog_on,
  input wire logic        osc_startup_timer_done,
  input wire logic        pll_locked,
  input wire logic        new_clock_tick,
  input wire logic [3:0]  osc_enable,
  input wire logic [2:0]  system_clock_sel,
  input wire logic [1:0]  primary_submode,
  input wire logic [15:0] peripheral_disable_1,
  input wire logic [15:0] peripheral_disable_5
);
  // ====================
  // Tick toggles since the source last moved; saturates so it never wraps.
  logic [2:0] sel_prev_reg;
  logic       tick_prev_reg;
  logic [3:0] tick_cnt_reg;
  logic [3:0] tick_cnt_next;
  // Count the raw pin; the design's synchroniser only adds delay to its own count.
  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    if (system_clock_sel != sel_prev_reg) begin
      tick_cnt_next = 4'h0;
    end else if (new_clock_tick != tick_prev_reg && tick_cnt_reg != 4'hF) begin
      tick_cnt_next = tick_cnt_reg + 4'h1;
    end
  end
  // Register the counter and the previous samples.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prev_reg  <= 3'h0;
      tick_prev_reg <= 1'b0;
      tick_cnt_reg  <= 4'h0;
    end else begin
      sel_prev_reg  <= system_clock_sel;
      tick_prev_reg <= new_clock_tick;
      tick_cnt_reg  <= tick_cnt_next;
    end
  end
  // Oscillator enable bit that feeds each source code.
  function automatic logic [1:0] src_bit(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: return 2'h2;
      3'h2, 3'h3: return 2'h0;
      3'h4: return 2'h1;
      default: return 2'h3;
    endcase
  endfunction
  // ====================
  // Properties.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A swap: the selected source moves once the straps have been taken.
  sequence s_swap;
    $past(presetn, 2) && system_clock_sel != $past(system_clock_sel);
  endsequence
  a_dis_cur_init: assert property (switch_monitor_cfg_n && $past(presetn) |->
    system_clock_sel == initial_source_cfg) else $error("source differs from strap");
  a_submode_fixed: assert property ($past(presetn, 2) |->
    $stable(primary_submode) && primary_submode == primary_submode_cfg)
    else $error("submode moved");
  a_swap_after_ten: assert property (s_swap |-> tick_cnt_reg >= `CSS_SETTLE_CYCLES)
    else $error("swap before ten new-clock cycles");
  a_new_osc_on: assert property (s_swap |-> osc_enable[src_bit(system_clock_sel)])
    else $error("new oscillator not running at swap");
  a_ost_first: assert property (s_swap |-> system_clock_sel != 3'h2 ||
    primary_submode != 2'h0 || $past(osc_startup_timer_done)) else $error("swap before startup");
  a_pll_lock_first: assert property (s_swap |->
    !(system_clock_sel inside {3'h1, 3'h3}) || $past(pll_locked)) else $error("swap before lock");
  a_old_pri_off: assert property (s_swap ##0 ($past(system_clock_sel[2:1]) == 2'h1 &&
    system_clock_sel[2:1] != 2'h1) |-> ##[0:4] !osc_enable[0]) else $error("old source on");
  a_low_power_rc_osc_kept: assert property ($past(presetn) && $past(osc_enable[3]) &&
    (watchdog_on || !switch_monitor_cfg_n) |-> osc_enable[3]) else $error("low-power rc off");
  a_dis1_write: assert property (psel && penable && pwrite && pstrb == 4'hF &&
    paddr == `CSS_PERIPH_DIS1_ADDR |=> peripheral_disable_1 ==
    ($past(pwdata[15:0]) & `CSS_DIS1_MASK)) else $error("disable 1 not written");
  a_dis5_write: assert property (psel && penable && pwrite && pstrb == 4'hF &&
    paddr == `CSS_PERIPH_DIS5_ADDR |=> peripheral_disable_5 ==
    ($past(pwdata[15:0]) & `CSS_DIS5_MASK)) else $error("disable 5 not written");
  a_unimpl_zero: assert property ((peripheral_disable_1 & ~`CSS_DIS1_MASK) == 16'h0 &&
    (peripheral_disable_5 & ~`CSS_DIS5_MASK) == 16'h0) else $error("unused disable bit set");
endmodule
bind css_clock_switch css_clock_switch_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .switch_monitor_cfg_n,
  .initial_source_cfg, .primary_submode_cfg, .watchdog_on, .osc_startup_timer_done,
  .pll_locked, .new_clock_tick, .osc_enable, .system_clock_sel, .primary_submode,
  .peripheral_disable_1, .peripheral_disable_5);

// *** test/css_clock_switch_tb.sv ***
// Self-checking testbench of the clock source switcher.
`timescale 1ns/1ps
`include "css_defines.svh"
module css_clock_switch_tb
  import css_pkg::*;
;
  // ====================
  // Design connections, each input valued at time zero.
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0, osc_running = 4'h0, osc_enable;
  logic        cfg_n = 1'b1, watchdog_on = 1'b0, keep_on = 1'b0, ost_done = 1'b0;
  logic        pll_locked = 1'b0, fail_evt = 1'b0, tick = 1'b0, tick_on = 1'b0, ost_hold = 1'b0;
  logic        pready, pslverr, pll_enable, slv;
  logic [1:0]  tick_div = 2'h0;  // Paces the new-clock tick to one toggle every fourth cycle.
  logic [2:0]  init_src = 3'h0, system_clock_sel;
  logic [1:0]  sub_cfg = 2'h0, primary_submode;
  logic [15:0] dis1, dis5;
  int          failures = 0, comparisons = 0;
  // Switch path; the two PLL modes are always followed by plain fast RC.
  localparam logic [2:0] PATH [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h0};
  css_clock_switch dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .switch_monitor_cfg_n(cfg_n), .initial_source_cfg(init_src),
    .primary_submode_cfg(sub_cfg), .watchdog_on, .secondary_osc_keep_on(keep_on), .osc_running,
    .osc_startup_timer_done(ost_done), .pll_locked, .clock_fail_event(fail_evt),
    .new_clock_tick(tick), .osc_enable, .pll_enable, .system_clock_sel, .primary_submode,
    .peripheral_disable_1(dis1), .peripheral_disable_5(dis5));
  always #12.5 pclk = ~pclk;
  // Oscillators answer a cycle after enable; the startup timer can be held back.
  // The tick holds each level four cycles: the three-stage filter of the design
  // only passes a level that two stages agree on, so a per-cycle toggle is lost.
  always @(posedge pclk) begin
    osc_running <= osc_enable;
    ost_done    <= osc_enable[0] & ~ost_hold;
    pll_locked  <= pll_enable;
    tick_div    <= tick_div + 2'h1;
    if (tick_on && tick_div == 2'h3) begin
      tick <= ~tick;
    end
  end
  // ====================
  // Tasks and expectation helpers.
  function automatic logic [1:0] src_bit(input logic [2:0] s);
    return (s < 3'h2) ? 2'h2 : (s < 3'h4) ? 2'h0 : (s == 3'h4) ? 2'h1 : 2'h3;
  endfunction
  task automatic results();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, then an idle cycle so no signal is driven twice in a step.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      results();
    end
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset(input logic dis, input logic [2:0] src, input logic [1:0] sub);
    presetn  <= 1'b0;
    cfg_n    <= dis;
    init_src <= src;
    sub_cfg  <= sub;
    repeat (10) @(posedge pclk);
    presetn  <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // Unlock, write next source, unlock, request; then poll until the request clears.
  task automatic sw(input logic [2:0] nxt, input logic [2:0] cur, input logic hold,
                    output logic first);
    int n;
    apb(`CSS_UNLOCK_ADDR, 1'b1, `CSS_KEY_HIGH, 4'hF);
    apb(`CSS_OSC_CONTROL_ADDR, 1'b1, {21'h0, nxt, 8'h00}, 4'h2);
    apb(`CSS_UNLOCK_ADDR, 1'b1, `CSS_KEY_LOW, 4'hF);
    ost_hold <= hold;
    apb(`CSS_OSC_CONTROL_ADDR, 1'b1, 32'h1, 4'h1);
    tick_on <= 1'b1;
    apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
    first = rd[0];
    if (hold) begin
      repeat (40) @(posedge pclk);
      apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
      check("request during startup", 32'({rd[0], system_clock_sel}), 32'({1'b1, cur}));
      ost_hold <= 1'b0;
    end
    for (n = 0; rd[0] !== 1'b0 && n < 100; n++) begin
      apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
    end
    if (n >= 100) begin
      failures++;
      results();
    end
    tick_on <= 1'b0;
  endtask
  // ====================
  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [15:0] m;
    logic [11:0] a;
    logic        first;
    logic [2:0]  cur;
    void'($urandom(32'h1355));
    @(posedge pclk);
    // Switching disabled: straps decide, the request bit stays low.
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b1, k ? 3'h5 : 3'h4, 2'($urandom % 3));
      apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
      check("current field", 32'(rd[14:12]), 32'(init_src));
      check("submode", 32'(primary_submode), 32'(sub_cfg));
      sw(3'h0, init_src, 1'b0, first);
      check("request held low", 32'(first), 32'h0);
      check("source kept", 32'(system_clock_sel), 32'(init_src));
    end
    do_reset(1'b0, 3'h0, 2'h0);
    // Disable registers: reset value, random and all-ones writes, unused bits.
    for (int i = 0; i < 14; i++) begin
      a = i[0] ? `CSS_PERIPH_DIS5_ADDR : `CSS_PERIPH_DIS1_ADDR;
      m = i[0] ? `CSS_DIS5_MASK : `CSS_DIS1_MASK;
      d = (i < 2) ? 32'h0 : (i > 11) ? 32'hFFFF_FFFF : $urandom;
      if (i >= 2) begin
        apb(a, 1'b1, d, 4'hF);
      end
      apb(a, 1'b0, 32'h0, 4'h0);
      check("disable readback", rd, {16'h0, d[15:0] & m});
      check("disable pins", 32'(i[0] ? dis5 : dis1), {16'h0, d[15:0] & m});
    end
    apb(12'h01C, 1'b0, 32'h0, 4'h0);
    check("unmapped error", 32'(slv), 32'h1);
    apb(`CSS_STATUS_ADDR, 1'b0, 32'h0, 4'h0);
    check("switching on", 32'(rd[4]), 32'h1);
    // An unlock spoilt by another write, then no unlock at all.
    apb(`CSS_UNLOCK_ADDR, 1'b1, `CSS_KEY_HIGH, 4'hF);
    apb(`CSS_PERIPH_DIS1_ADDR, 1'b1, 32'h0, 4'hF);
    apb(`CSS_OSC_CONTROL_ADDR, 1'b1, 32'h0000_0400, 4'h2);
    apb(`CSS_OSC_CONTROL_ADDR, 1'b1, 32'h0000_0500, 4'h2);
    apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
    check("next field locked", 32'(rd[10:8]), 32'h0);
    fail_evt <= 1'b1;
    repeat (8) @(posedge pclk);
    fail_evt <= 1'b0;
    apb(`CSS_OSC_CONTROL_ADDR, 1'b0, 32'h0, 4'h0);
    check("fail flag set", 32'(rd[3]), 32'h1);
    sw(3'h0, 3'h0, 1'b0, first);
    check("redundant switch", 32'({rd[0], system_clock_sel}), 32'h0);
    // Walk every source code; the first step holds the crystal startup timer.
    cur = 3'h0;
    foreach (PATH[i]) begin
      keep_on     <= 1'($urandom);
      watchdog_on <= 1'($urandom);
      sw(PATH[i], cur, i == 0, first);
      check("request while switching", 32'(first), 32'h1);
      check("source", 32'({rd[14:12], system_clock_sel}), 32'({PATH[i], PATH[i]}));
      check("fail flag cleared", 32'(rd[3]), 32'h0);
      if (PATH[i] inside {3'h1, 3'h3}) begin
        check("lock", 32'(rd[5]), 32'h1);
      end
      check("new osc on", 32'(osc_enable[src_bit(PATH[i])]), 32'h1);
      if (src_bit(cur) != src_bit(PATH[i])) begin
        check("old osc", 32'(osc_enable[src_bit(cur)]),
              32'(cur == 3'h5 || (cur == 3'h4 && keep_on)));
      end
      cur = PATH[i];
    end
    results();
  end
endmodule
